/* shared/csio_pkg.sv */
package csio_pkg;
   // Register indices on the plain port
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_CTRL0 = 4'h1;
   localparam logic [3:0] ADDR_CTRL1 = 4'h2;
   localparam logic [3:0] ADDR_SMR1 = 4'h3;
   localparam logic [3:0] ADDR_SMR2 = 4'h4;
   localparam logic [3:0] ADDR_SMR3 = 4'h5;
   localparam logic [3:0] ADDR_SMR4 = 4'h6;
   localparam logic [3:0] ADDR_BAUD = 4'h7;
   localparam logic [3:0] ADDR_TXBUF = 4'h8;
   localparam logic [3:0] ADDR_RXBUF = 4'h9;
   localparam logic [3:0] ADDR_SHARED = 4'ha;
   localparam logic [3:0] ADDR_PINSEL = 4'hb;
   // Mode register fields
   localparam int MODE_CLOCK_DIRECTION_SEL_BIT = 3;
   localparam logic [2:0] MODE_SYNC = 3'h1;
   // Control zero fields
   localparam int C0_ORDER_BIT = 7;
   localparam int C0_POL_BIT = 6;
   localparam int C0_OD_BIT = 5;
   localparam int C0_CRD_BIT = 4;
   localparam int C0_TX_SHIFT_EMPTY_FLAG_BIT = 3;
   // Control one fields
   localparam int C1_INV_BIT = 6;
   localparam int C1_RRM_BIT = 5;
   localparam int C1_IRS_BIT = 4;
   localparam int C1_RI_BIT = 3;
   localparam int C1_RE_BIT = 2;
   localparam int C1_TI_BIT = 1;
   localparam int C1_TE_BIT = 0;
   // Shared control fields (channels 3 and 4)
   localparam int SH_RRM_BIT = 1;
   localparam int SH_IRS_BIT = 0;
   localparam int PINSEL_BIT = 4;
   localparam int RB_OER_BIT = 12;
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_C0 = 8'h08;
   localparam logic [7:0] RST_C1 = 8'h02;
   // Bit count of one character
   localparam logic [3:0] CHAR_BITS = 4'h8;
   localparam logic [3:0] OVR_BIT = 4'h7;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } csio_req_type;

   // Shift engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_TRAIL = 2'b10
   } csio_state_type;
endpackage

/* rtl/csio_channel.sv */
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module csio_channel #(
   parameter int CHANNEL = 0, // Channel number 0 to 4
   parameter int F2N_DIV = 4 // Half the divide ratio of the f2n source
) (
   input wire logic clk, // System clock, 100 MHz
   input wire logic nrst, // Async reset, active low
   input wire csio_pkg::csio_req_type req, // Register request
   output logic [15:0] rdata, // Read data, cycle after read
   input wire logic shift_clock_pin_in, // Clock pin input
   output logic shift_clock_pin_out, // Clock pin output level
   output logic shift_clock_pin_oe_n, // Clock pin drive, low drives
   input wire logic serial_in_pin, // Receive data pin
   input wire logic ch4_serial_in_pin, // Alternate receive pin
   input wire logic ch4_shift_clock_pin, // Alternate clock pin
   input wire logic ch4_clear_to_send_pin, // Alternate CTS pin
   output logic serial_out_pin_out, // Transmit pin level
   output logic serial_out_pin_oe_n, // Transmit drive, low drives
   input wire logic clear_to_send_pin, // CTS input, low allows
   output logic tx_irq_pulse, // Transmit interrupt event
   output logic rx_irq_pulse // Receive interrupt event
);
   import csio_pkg::*;

   logic [7:0] mode_reg; // Mode select
   logic [7:0] c0_reg; // Control zero writable bits
   logic [7:0] c1_reg; // Control one writable bits
   logic [7:0] smr1, smr2, smr3, smr4; // Special mode registers
   logic [7:0] baud; // Baud divider
   logic [7:0] shared_reg; // Shared channel 3/4 control
   logic [7:0] pinsel_reg; // Input pin select
   logic [7:0] tx_buf; // Transmit buffer
   logic tx_empty; // Transmit buffer empty flag
   logic [7:0] rx_buf; // Receive buffer
   logic rx_full; // Receive complete flag
   logic overrun; // Overrun flag
   logic rx_armed; // Continuous receive armed
   logic [7:0] tx_sh, rx_sh; // Shift registers
   logic [3:0] bit_cnt; // Bits done in character
   logic sending; // Shift register busy
   logic out_q; // Transmit data register
   logic started; // First send has begun
   csio_state_type state; // Internal clock phase
   logic [7:0] pre_cnt, brg_cnt; // Prescaler, divider
   logic [2:0] ck_s, rx_s, cts_s; // Pin synchronisers
   logic [15:0] rdata_q; // Read data register

   // Pin select for channel 4 inputs
   wire alt_sel = (CHANNEL == 4) && pinsel_reg[PINSEL_BIT];
   wire ck_pin = alt_sel ? ch4_shift_clock_pin : shift_clock_pin_in;
   wire rx_pin = alt_sel ? ch4_serial_in_pin : serial_in_pin;
   wire cts_pin = alt_sel ? ch4_clear_to_send_pin : clear_to_send_pin;

   // Decoded configuration
   wire enabled = mode_reg[2:0] == MODE_SYNC;
   wire ext_clk = mode_reg[MODE_CLOCK_DIRECTION_SEL_BIT];
   wire msb_first = c0_reg[C0_ORDER_BIT];
   wire pol = c0_reg[C0_POL_BIT];
   wire odrain = (CHANNEL < 3) && c0_reg[C0_OD_BIT];
   wire use_cts = !c0_reg[C0_CRD_BIT];
   wire [1:0] src_sel = c0_reg[1:0];
   wire inv = (CHANNEL < 3) && c1_reg[C1_INV_BIT];
   wire share = CHANNEL >= 3;
   wire rrm = share ? shared_reg[SH_RRM_BIT] : c1_reg[C1_RRM_BIT];
   wire irs = share ? shared_reg[SH_IRS_BIT] : c1_reg[C1_IRS_BIT];
   wire te = c1_reg[C1_TE_BIT];
   wire re = c1_reg[C1_RE_BIT];
   wire cts_ok = !use_cts || !cts_s[2];
   // Start a character: data ready and partner allows
   wire go = enabled && te && !tx_empty && cts_ok && !sending;
   wire rx_on = re && te;

   // Register access decode
   wire wr_mode = req.wr && req.addr == ADDR_MODE;
   wire wr_tb = req.wr && req.addr == ADDR_TXBUF;
   wire rd_rb = req.rd && req.addr == ADDR_RXBUF;

   // Prescaler: f1, f8 or f2n picks the divider tick
   wire [7:0] pre_top = src_sel == 2'h1 ? 8'h07 :
      src_sel == 2'h2 ? 8'(2 * F2N_DIV - 1) : 8'h00;
   wire pre_tick = pre_cnt == pre_top;
   // Divider: half period is m+1 source ticks
   wire half_tick = pre_tick && brg_cnt == baud;

   // Synchronised external clock edges; bit 2 is the older sample
   wire ext_rise = ck_s[2:1] == 2'b01;
   wire ext_fall = ck_s[2:1] == 2'b10;
   // Leading edge shifts data out, trailing samples in
   wire int_lead = !ext_clk && state == ST_LEAD && half_tick;
   wire int_trail = !ext_clk && state == ST_TRAIL && half_tick;
   wire lead = sending && (ext_clk ? (pol ? ext_rise : ext_fall)
      : int_lead);
   wire trail = sending && (ext_clk ? (pol ? ext_fall : ext_rise)
      : int_trail);
   wire rx_bit = rx_s[2] ^ inv;
   wire last = trail && bit_cnt == CHAR_BITS - 4'h1;
   wire [7:0] rx_next = msb_first ? {rx_sh[6:0], rx_bit}
      : {rx_bit, rx_sh[7:1]};
   // Overrun once seventh bit of next character lands unread
   wire ovr_hit = trail && bit_cnt == OVR_BIT - 4'h1 && rx_full
      && rx_armed;

   // Pin synchronisers, three flops before use
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ck_s <= 3'h7; // Idle high as polarity resets to 0
         rx_s <= 3'h0;
         cts_s <= 3'h7;
      end else begin
         ck_s <= {ck_s[1:0], ck_pin};
         rx_s <= {rx_s[1:0], rx_pin};
         cts_s <= {cts_s[1:0], cts_pin};
      end
   end

   // Plain configuration registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= RST_ZERO;
         c0_reg <= RST_C0;
         c1_reg <= RST_C1;
         smr1 <= RST_ZERO;
         smr2 <= RST_ZERO;
         smr3 <= RST_ZERO;
         smr4 <= RST_ZERO;
         baud <= RST_ZERO;
         shared_reg <= RST_ZERO;
         pinsel_reg <= RST_ZERO;
      end else if (req.wr) begin
         case (req.addr)
            ADDR_MODE: mode_reg <= req.wdata;
            ADDR_CTRL0: c0_reg <= req.wdata;
            ADDR_CTRL1: c1_reg <= req.wdata;
            ADDR_SMR1: smr1 <= req.wdata;
            ADDR_SMR2: smr2 <= req.wdata;
            ADDR_SMR3: smr3 <= req.wdata;
            ADDR_SMR4: smr4 <= req.wdata;
            ADDR_BAUD: baud <= req.wdata;
            ADDR_SHARED: shared_reg <= req.wdata;
            ADDR_PINSEL: pinsel_reg <= req.wdata;
            default: ;
         endcase
      end
   end

   // Prescaler and baud divider, idle between characters
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_cnt <= 8'h00;
         brg_cnt <= 8'h00;
      end else if (!sending || ext_clk) begin
         pre_cnt <= 8'h00;
         brg_cnt <= 8'h00;
      end else if (pre_tick) begin
         pre_cnt <= 8'h00;
         brg_cnt <= half_tick ? 8'h00 : brg_cnt + 8'h01;
      end else begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end

   // Internal clock phase; rests at idle level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: if (go && !ext_clk) state <= ST_LEAD;
            ST_LEAD: if (half_tick) state <= ST_TRAIL;
            ST_TRAIL: begin
               if (half_tick) state <= (bit_cnt == CHAR_BITS - 4'h1)
                  ? ST_IDLE : ST_LEAD;
            end
            default: state <= ST_IDLE;
         endcase
         if (!enabled) state <= ST_IDLE;
      end
   end

   // Transmit buffer and shift engine
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_buf <= 8'h00;
         tx_empty <= 1'b1;
         tx_sh <= 8'h00;
         rx_sh <= 8'h00;
         bit_cnt <= 4'h0;
         sending <= 1'b0;
         out_q <= 1'b1;
         started <= 1'b0;
      end else begin
         if (wr_tb) begin
            tx_buf <= req.wdata;
            tx_empty <= 1'b0;
         end
         if (!enabled) begin
            sending <= 1'b0;
            started <= 1'b0;
            out_q <= 1'b1;
         end else if (go) begin
            tx_sh <= tx_buf; // Load takes the old buffer; a same-cycle write stays queued
            tx_empty <= wr_tb ? 1'b0 : 1'b1;
            sending <= 1'b1;
            started <= 1'b1;
            bit_cnt <= 4'h0;
         end else begin
            if (lead) begin
               out_q <= (msb_first ? tx_sh[7] : tx_sh[0]) ^ inv;
               tx_sh <= msb_first ? {tx_sh[6:0], 1'b0}
                  : {1'b0, tx_sh[7:1]};
            end
            if (trail) begin
               rx_sh <= rx_next;
               bit_cnt <= bit_cnt + 4'h1;
               if (last) sending <= 1'b0;
            end
         end
      end
   end

   // Receive buffer, flags and continuous receive
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_buf <= 8'h00;
         rx_full <= 1'b0;
         overrun <= 1'b0;
         rx_armed <= 1'b1;
      end else if (!enabled || !re) begin
         rx_full <= 1'b0; // Recovery path clears errors
         overrun <= 1'b0;
         rx_armed <= 1'b1;
      end else begin
         if (rd_rb) begin
            rx_full <= 1'b0;
            overrun <= 1'b0;
            if (rrm) rx_armed <= 1'b1;
         end
         if (ovr_hit) overrun <= 1'b1;
         if (last && rx_on && rx_armed) begin
            rx_buf <= rx_next;
            rx_full <= 1'b1; // Set wins over read clear
            if (rrm) rx_armed <= 1'b0;
         end
      end
   end

   // Interrupt events: start or completion; no receive event on overrun
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_irq_pulse <= 1'b0;
         rx_irq_pulse <= 1'b0;
      end else begin
         tx_irq_pulse <= irs ? last : (go && enabled);
         rx_irq_pulse <= last && rx_on && rx_armed && re
            && !overrun && !ovr_hit;
      end
   end

   // Read data, valid one cycle after the strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
      end else if (req.rd) begin
         case (req.addr)
            ADDR_MODE: rdata_q <= {8'h00, mode_reg};
            ADDR_CTRL0: rdata_q <= {8'h00, c0_reg[7:4], !sending,
               c0_reg[2:0]};
            ADDR_CTRL1: rdata_q <= {8'h00, c1_reg[7:4], rx_full,
               c1_reg[2], tx_empty, c1_reg[0]};
            ADDR_SMR1: rdata_q <= {8'h00, smr1};
            ADDR_SMR2: rdata_q <= {8'h00, smr2};
            ADDR_SMR3: rdata_q <= {8'h00, smr3};
            ADDR_SMR4: rdata_q <= {8'h00, smr4};
            ADDR_BAUD: rdata_q <= {8'h00, baud};
            ADDR_RXBUF: rdata_q <= {3'h0, overrun, 4'h0, rx_buf};
            ADDR_SHARED: rdata_q <= {8'h00, shared_reg};
            ADDR_PINSEL: rdata_q <= {8'h00, pinsel_reg};
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   // Pin drive: internal clock idles at the inverse of polarity
   assign rdata = rdata_q;
   assign shift_clock_pin_out = (state == ST_TRAIL) ? pol : !pol;
   assign shift_clock_pin_oe_n = !(enabled && !ext_clk);
   assign serial_out_pin_out = started ? out_q : 1'b1;
   assign serial_out_pin_oe_n = !enabled ||
      (odrain && (!started || out_q));
endmodule
`default_nettype wire

/* tb/csio_channel_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module csio_channel_checker (
   input wire logic clk, // System clock
   input wire logic nrst, // Reset, active low
   input wire csio_pkg::csio_req_type req, // Register request
   input wire logic [15:0] rdata, // Read data
   input wire logic shift_clock_pin_out, // Clock level
   input wire logic shift_clock_pin_oe_n, // Clock drive, low drives
   input wire logic serial_out_pin_out, // Transmit level
   input wire logic serial_out_pin_oe_n, // Transmit drive
   input wire logic tx_irq_pulse, // Transmit event
   input wire logic rx_irq_pulse // Receive event
);
   import csio_pkg::*;
   logic [7:0] mode_sh, c0_sh, c1_sh, baud_sh; // Written settings
   logic sent; // A character was queued
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Shadow of what software wrote
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_sh <= RST_ZERO;
         c0_sh <= RST_C0;
         c1_sh <= RST_C1;
         baud_sh <= RST_ZERO;
         sent <= 1'b0;
      end else if (req.wr) begin
         case (req.addr)
            ADDR_MODE: mode_sh <= req.wdata;
            ADDR_CTRL0: c0_sh <= req.wdata;
            ADDR_CTRL1: c1_sh <= req.wdata;
            ADDR_BAUD: baud_sh <= req.wdata;
            ADDR_TXBUF: sent <= 1'b1;
            default: ;
         endcase
      end
   end
   a_rdata_quiet: assert property (!req.rd |=> rdata == 16'h0000)
      else $error("read data present without a read");
   a_tx_one_cycle: assert property (tx_irq_pulse |=> !tx_irq_pulse)
      else $error("transmit event longer than one cycle");
   a_rx_needs_en: assert property (
      rx_irq_pulse |-> c1_sh[C1_RE_BIT] && c1_sh[C1_TE_BIT])
      else $error("receive event while disabled");
   a_out_first_high: assert property (
      !sent && !serial_out_pin_oe_n |-> serial_out_pin_out)
      else $error("transmit pin low before first send");
   a_open_drain: assert property (
      c0_sh[C0_OD_BIT] && $stable(c0_sh) && serial_out_pin_out
      |-> serial_out_pin_oe_n)
      else $error("open drain pin driven high");
   a_clk_drive_mode: assert property (
      $fell(shift_clock_pin_oe_n) |-> mode_sh[3:0] == 4'h1)
      else $error("clock driven outside internal mode");
   a_half_period: assert property (
      !shift_clock_pin_oe_n && $changed(shift_clock_pin_out)
      && baud_sh == 8'h03 && c0_sh[1:0] == 2'b00
      |=> $stable(shift_clock_pin_out) [*3] ##1
      ($changed(shift_clock_pin_out)
      || shift_clock_pin_out != c0_sh[C0_POL_BIT]))
      else $error("clock half period wrong");
   a_idle_after_rx: assert property (
      rx_irq_pulse && !shift_clock_pin_oe_n
      |-> shift_clock_pin_out != c0_sh[C0_POL_BIT])
      else $error("clock not idle after a character");
   a_no_clk_no_te: assert property (
      !c1_sh[C1_TE_BIT] && !shift_clock_pin_oe_n
      |=> $stable(shift_clock_pin_out))
      else $error("clock moves with transmit disabled");
endmodule
bind csio_channel csio_channel_checker i_chk (.clk(clk), .nrst(nrst),
   .req(req), .rdata(rdata), .shift_clock_pin_out(shift_clock_pin_out),
   .shift_clock_pin_oe_n(shift_clock_pin_oe_n),
   .serial_out_pin_out(serial_out_pin_out),
   .serial_out_pin_oe_n(serial_out_pin_oe_n),
   .tx_irq_pulse(tx_irq_pulse), .rx_irq_pulse(rx_irq_pulse));
`default_nettype wire

/* tb/csio_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module csio_peer (
   input wire logic sck, // Shift clock wire
   input wire logic pol, // Polarity the device uses
   input wire logic sdo, // Device transmit wire
   input wire logic [7:0] send, // Bits to return, first at bit 0
   output logic sck_drv, // Clock level while the device releases it
   output logic sdi, // Data toward the device
   output logic [7:0] got // Bits seen, first at bit 0
);
   int idx = 0; // Bit position in the frame
   logic mid = 1'b0; // Between leading and trailing edge
   logic prev; // Last clock level
   assign sck_drv = !pol; // Idle level outside frames
   initial sdi = 1'b1;
   initial got = 8'h00;
   // Leading edge presents a bit, trailing edge captures one
   always @(sck) begin
      if (sck === pol && prev === !pol) begin
         mid = 1'b1;
         sdi = send[idx];
      end else if (sck === !pol && mid) begin
         mid = 1'b0;
         got[idx] = sdo;
         idx = (idx + 1) % 8;
         if (idx == 0) sdi = ~sdi; // Released line must not hold last bit
      end
      prev = sck;
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import csio_pkg::*;
   logic clk = 1'b0; // System clock
   logic nrst = 1'b0; // Reset, active low
   csio_req_type req = '0; // Register request
   logic [15:0] rdata; // Read data
   logic sck_out, sck_oe_n, sdo_out, sdo_oe_n, tx_irq, rx_irq; // Outputs
   logic sck_drv, sdi, cts = 1'b1, pol = 1'b0; // Far side
   logic ext_tog = 1'b0; // Partner clock burst, flips idle level
   logic [7:0] send = 8'h00, got; // Peer frame bits
   wire logic sck_wire = sck_oe_n ? sck_drv ^ ext_tog : sck_out; // Clock pin
   wire logic sdo_wire = sdo_oe_n ? 1'b1 : sdo_out; // Pulled up
   int err_total = 0, checked = 0, cyc = 0, tx_t = 0, rx_t = 0, rx_n = 0;
   csio_channel #(.CHANNEL(0), .F2N_DIV(4)) i_dut (.clk(clk), .nrst(nrst),
      .req(req), .rdata(rdata), .shift_clock_pin_in(sck_wire),
      .shift_clock_pin_out(sck_out), .shift_clock_pin_oe_n(sck_oe_n),
      .serial_in_pin(sdi), .ch4_serial_in_pin(1'b1),
      .ch4_shift_clock_pin(1'b1), .ch4_clear_to_send_pin(1'b1),
      .serial_out_pin_out(sdo_out), .serial_out_pin_oe_n(sdo_oe_n),
      .clear_to_send_pin(cts), .tx_irq_pulse(tx_irq), .rx_irq_pulse(rx_irq));
   csio_peer i_peer (.sck(sck_wire), .pol(pol), .sdo(sdo_wire),
      .send(send), .sck_drv(sck_drv), .sdi(sdi), .got(got));
   always #5 clk = ~clk; // 100 MHz
   // Event times, receive count and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tx_irq === 1'b1) tx_t <= cyc;
      if (rx_irq === 1'b1) rx_t <= cyc;
      if (rx_irq === 1'b1) rx_n <= rx_n + 1;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One write, then one idle edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
   // One read, data taken in the cycle after; mask k hides undefined bits
   task automatic rdc(input logic [3:0] a, input logic [15:0] e,
      input logic [15:0] k = 16'hffff);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1 cmp(rdata & k, e);
      @(posedge clk);
   endtask
   task automatic wait_rx(input int n0);
      repeat (200) if (rx_n == n0) @(posedge clk);
   endtask
   // Wire order of a byte for a given order and inversion
   function automatic logic [7:0] wbits(input logic [7:0] d, input logic m,
      input logic inv);
      logic [7:0] v;
      v = inv ? ~d : d;
      wbits = v;
      for (int k = 0; k < 8; k++) if (m) wbits[k] = v[7 - k];
   endfunction
   task automatic t_idle_pins();
      rdc(ADDR_CTRL0, {8'h00, RST_C0});
      rdc(ADDR_CTRL1, {8'h00, RST_C1});
      rdc(4'hf, 16'h0000); // Unmapped place reads zero
      for (int a = 3; a <= 6; a++) begin
         wr(4'(a), 8'h00);
      end
      wr(ADDR_MODE, 8'h01);
      @(negedge clk);
      cmp({14'h0, sdo_out, sdo_oe_n}, 16'h0002);
      @(posedge clk);
      wr(ADDR_CTRL0, 8'h30); // Open drain, no flow control
      @(negedge clk);
      cmp({14'h0, sdo_wire, sdo_oe_n}, 16'h0003);
      @(posedge clk);
      wr(ADDR_CTRL0, 8'h10);
   endtask
   task automatic t_xfer(input logic m, p, inv, irs, input logic [7:0] d, s);
      logic [7:0] c1;
      int n0;
      c1 = {1'b0, inv, 1'b0, irs, 4'h5};
      pol = p; // Peer first, so the idle change is no edge
      send = s;
      n0 = rx_n;
      wr(ADDR_CTRL0, {m, p, 6'h10});
      wr(ADDR_CTRL1, c1);
      wr(ADDR_TXBUF, d);
      rdc(ADDR_CTRL0, {8'h00, m, p, 6'h10});
      wait_rx(n0);
      cmp(16'(rx_n - n0), 16'h0001);
      cmp({8'h00, got}, {8'h00, wbits(d, m, inv)});
      rdc(ADDR_CTRL1, {8'h00, c1 | 8'h0a});
      rdc(ADDR_RXBUF, {8'h00, wbits(s, m, inv)});
      cmp({15'h0, rx_t - tx_t > 16}, {15'h0, !irs});
   endtask
   task automatic t_overrun();
      int n0;
      n0 = rx_n;
      wr(ADDR_TXBUF, 8'h33);
      wait_rx(n0);
      wr(ADDR_TXBUF, 8'h44); // Second character, buffer unread
      repeat (150) @(posedge clk);
      cmp(16'(rx_n - n0), 16'h0001);
      rdc(ADDR_RXBUF, 16'h1000, 16'hff00);
      wr(ADDR_CTRL1, 8'h01);
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_CTRL1, 8'h05);
   endtask
   task automatic t_cts();
      int n0;
      n0 = rx_n;
      wr(ADDR_CTRL0, 8'h00);
      wr(ADDR_TXBUF, 8'h77);
      repeat (100) @(posedge clk);
      cmp(16'(rx_n - n0), 16'h0000);
      cts <= 1'b0;
      wait_rx(n0);
      cmp(16'(rx_n - n0), 16'h0001);
      rdc(ADDR_RXBUF, {8'h00, send});
   endtask
   // Partner clocks one frame, half period of 6 cycles
   task automatic burst();
      repeat (16) begin
         repeat (6) @(posedge clk);
         ext_tog <= ~ext_tog;
      end
   endtask
   // External clock with continuous receive: second frame not taken
   task automatic t_ext();
      int n0;
      n0 = rx_n;
      send = 8'ha5;
      wr(ADDR_MODE, 8'h09);
      wr(ADDR_CTRL0, 8'h10);
      wr(ADDR_CTRL1, 8'h25);
      wr(ADDR_TXBUF, 8'h6c);
      burst();
      wait_rx(n0);
      cmp(16'(rx_n - n0), 16'h0001);
      cmp({8'h00, got}, 16'h006c);
      wr(ADDR_TXBUF, 8'h93);
      burst();
      repeat (20) @(posedge clk);
      cmp(16'(rx_n - n0), 16'h0001);
      cmp({8'h00, got}, 16'h0093);
      rdc(ADDR_RXBUF, 16'h00a5);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      cmp({15'h0, sdo_out}, 16'h0001);
      nrst <= 1'b1;
      @(posedge clk);
      t_idle_pins();
      wr(ADDR_BAUD, 8'h03);
      t_xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h1d, 8'hc6);
      t_xfer(1'b1, 1'b0, 1'b0, 1'b1, 8'h3a, 8'h5b);
      t_xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'he1, 8'h27);
      t_xfer(1'b1, 1'b1, 1'b1, 1'b1, 8'h96, 8'h0f);
      t_overrun();
      t_xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h81, 8'h7e);
      t_cts();
      t_ext();
      tally_and_finish();
   end
endmodule
`default_nettype wire
